// >>> timer_counter_consts.svh
// Operation
// - 16-bit up-counter, 8-bit control, period and compare registers.
// - mode: 00 timer/trigger/event, 01 window, 10 pulse width, 11 generator.
// - prescale codes 00/01/10 divide by 2^11/2^7/2^3; halve doubles.
// - clock select 11 counts on the input pin instead of the prescaler.
// - start 00 halts and clears; 01 starts at once in timer/generator modes.
// - start 10: rising pin edge starts, or counts in event mode.
// - start 11: falling pin edge starts, or counts in event mode.
// - window mode counts while pin high (10) or low (11).
// - trigger-stop bit 0: trigger edge starts, opposite edge stops; 1: start only.
// - pulse width: capture bit 1 single-edge, 0 double-edge capture.
// - two-stage timer registers; load at first tick after upper byte.
// - stop entry clears start control to 00; stays stopped until rewritten.
// - auto-capture copies counter each tick; first read a tick later.
`ifndef TIMER_COUNTER_CONSTS_SVH
`define TIMER_COUNTER_CONSTS_SVH

// register byte addresses, one 32-bit word each
`define ADDR_TIMER_CONTROL 5'h00
`define ADDR_PERIOD 5'h04
`define ADDR_COMPARE 5'h08
`define ADDR_STATUS 5'h0C
`define ADDR_CLOCK_CONFIG 5'h10

// reset values
`define RST_TIMER_CONTROL 8'h00
`define RST_TIMER_REG 16'hFFFF

// status field positions
`define STATUS_RUN_BIT 16
`define STATUS_PEND_PERIOD_BIT 17
`define STATUS_PEND_COMPARE_BIT 18

// prescale shifts for codes 00, 01, 10
`define SHIFT_CODE0 4'd11
`define SHIFT_CODE1 4'd7
`define SHIFT_CODE2 4'd3

`endif

// >>> timer_counter_pkg.sv
package timer_counter_pkg;

  // control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic output_flipflop_control;
    logic mode_bit;
    logic [1:0] start_control;
    logic [1:0] source_clock_select;
    logic [1:0] operating_mode_select;
  } timer_control_t;

  typedef enum logic [1:0] {
    mode_basic,
    mode_window,
    mode_pulse_width,
    mode_pulse_generator
  } op_mode_t;

  typedef enum {
    st_stopped,
    st_wait,
    st_run
  } run_state_t;

endpackage : timer_counter_pkg

// >>> pin_edge_sync.sv
`timescale 1ns/10ps
// two-flop synchroniser with edge detect for the timer input pin
module pin_edge_sync
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic pin_async,
  output logic level,
  output logic rise,
  output logic fall
);
  logic meta;
  logic prev;

  // meta is read only by level
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      meta <= 1'b0;
      level <= 1'b0;
      prev <= 1'b0;
    end
    else
    begin
      meta <= pin_async;
      level <= meta;
      prev <= level;
    end
  end

  assign rise = level & ~prev;
  assign fall = ~level & prev;

  edge_single_a: assert property (@(posedge core_clk) disable iff (rst)
    rise |=> !rise && level)
    else $error("pin rise lasted more than one cycle");

endmodule : pin_edge_sync

// >>> timer_counter_one_control.sv
`timescale 1ns/10ps
`include "timer_counter_consts.svh"
module timer_counter_one_control
  import timer_counter_pkg::*;
#(
  parameter int PRESCALE_W = 13
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic stop_entry,
  input wire logic timer_input_pin,
  output logic pulse_out,
  output logic match_event
);

  // refuse widths that cannot hold the widest divide ratio
  if (PRESCALE_W < 13)
  begin : g_width_check
    $error("PRESCALE_W too small for the 2^12 ratio");
  end

  ////////////////////////////////////////////////////////////////////////
  // declarations

  timer_control_t ctrl;
  logic prescale_halve_select;
  logic [15:0] period_stage;
  logic [15:0] period_active;
  logic [15:0] compare_stage;
  logic [15:0] compare_active;
  logic period_pend;
  logic compare_pend;
  logic [15:0] counter;
  logic [PRESCALE_W-1:0] prescale;
  logic [PRESCALE_W-1:0] tick_mask;
  run_state_t state;
  op_mode_t mode;
  logic pin_level;
  logic pin_rise;
  logic pin_fall;
  logic presc_tick;
  logic src_tick;
  logic trig_edge;
  logic opp_edge;
  logic wr_go;
  logic rd_go;
  logic cap_go;
  logic at_period;
  logic event_mode;
  logic trigger_mode;
  logic period_upper_wr;
  logic compare_upper_wr;
  logic compare_wr_ok;

  ////////////////////////////////////////////////////////////////////////
  // input pin crossing

  pin_edge_sync pin_sync
  (
    .core_clk(core_clk),
    .rst(rst),
    .pin_async(timer_input_pin),
    .level(pin_level),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  ////////////////////////////////////////////////////////////////////////
  // mode decode

  // bit 6 is shared: capture, trigger-stop, capture-edge or shot select
  assign mode = op_mode_t'(ctrl.operating_mode_select);
  assign event_mode = (mode == mode_basic) &&
                      (ctrl.source_clock_select == 2'h3);
  assign trigger_mode = (mode == mode_basic) && !event_mode &&
                        ctrl.start_control[1];
  // start 10 picks the rising edge, 11 the falling one
  assign trig_edge = ctrl.start_control[0] ? pin_fall : pin_rise;
  assign opp_edge = ctrl.start_control[0] ? pin_rise : pin_fall;

  ////////////////////////////////////////////////////////////////////////
  // prescaler and source tick

  // free-running divider; a tick when the low bits are all ones
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      prescale <= '0;
    else
      prescale <= prescale + 1'b1;
  end

  // halve setting adds one to the shift, doubling the ratio
  always_comb
  begin
    logic [3:0] shift;
    shift = `SHIFT_CODE0;
    case (ctrl.source_clock_select)
      2'h0: shift = `SHIFT_CODE0;
      2'h1: shift = `SHIFT_CODE1;
      2'h2: shift = `SHIFT_CODE2;
      default: shift = `SHIFT_CODE2;
    endcase
    shift = shift + {3'h0, prescale_halve_select};
    tick_mask = PRESCALE_W'((1 << shift) - 1);
  end

  assign presc_tick = (prescale & tick_mask) == tick_mask;
  // external clock: the pin edge chosen by start control
  assign src_tick = (ctrl.source_clock_select == 2'h3) ?
                    (ctrl.start_control == 2'h3 ? pin_fall : pin_rise) :
                    presc_tick;

  ////////////////////////////////////////////////////////////////////////
  // avalon slave handshake

  // one wait cycle, then waitrequest low for exactly one cycle
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      waitrequest <= 1'b1;
    else
      waitrequest <= !((read || write) && waitrequest);
  end

  assign wr_go = write && !waitrequest;
  assign rd_go = read && waitrequest;
  assign period_upper_wr = wr_go && (address == `ADDR_PERIOD) &&
                           byteenable[1];
  assign compare_wr_ok = mode == mode_pulse_generator;
  assign compare_upper_wr = wr_go && (address == `ADDR_COMPARE) &&
                            byteenable[1] && compare_wr_ok;

  // read data latched with the drop of waitrequest
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      readdata <= 32'h0;
    else if (rd_go)
    begin
      case (address)
        `ADDR_TIMER_CONTROL: readdata <= {24'h0, ctrl};
        `ADDR_PERIOD: readdata <= {16'h0, period_active};
        `ADDR_COMPARE: readdata <= {16'h0, compare_active};
        `ADDR_STATUS:
          readdata <= {13'h0, compare_pend, period_pend,
                       state == st_run, counter};
        `ADDR_CLOCK_CONFIG: readdata <= {31'h0, prescale_halve_select};
        default: readdata <= 32'h0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control register

  // stop entry beats a software write in the same cycle
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      ctrl <= `RST_TIMER_CONTROL;
    else if (stop_entry)
      ctrl.start_control <= 2'h0;
    else if (wr_go && address == `ADDR_TIMER_CONTROL && byteenable[0])
      ctrl <= writedata[7:0];
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      prescale_halve_select <= 1'b0;
    else if (wr_go && address == `ADDR_CLOCK_CONFIG && byteenable[0])
      prescale_halve_select <= writedata[0];
  end

  ////////////////////////////////////////////////////////////////////////
  // two-stage timer registers

  // byte lanes: lane 0 lower byte, lane 1 upper byte
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      period_stage <= `RST_TIMER_REG;
      compare_stage <= `RST_TIMER_REG;
    end
    else if (wr_go && address == `ADDR_PERIOD)
    begin
      if (byteenable[0])
        period_stage[7:0] <= writedata[7:0];
      if (byteenable[1])
        period_stage[15:8] <= writedata[15:8];
    end
    else if (wr_go && address == `ADDR_COMPARE && compare_wr_ok)
    begin
      if (byteenable[0])
        compare_stage[7:0] <= writedata[7:0];
      if (byteenable[1])
        compare_stage[15:8] <= writedata[15:8];
    end
  end

  // an upper write arms the copy; a fresh write wins over the tick
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      period_pend <= 1'b0;
    else if (period_upper_wr)
      period_pend <= 1'b1;
    else if (src_tick)
      period_pend <= 1'b0;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      compare_pend <= 1'b0;
    else if (compare_upper_wr)
      compare_pend <= 1'b1;
    else if (src_tick)
      compare_pend <= 1'b0;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      period_active <= `RST_TIMER_REG;
    else if (period_pend && src_tick)
      period_active <= period_stage;
  end

  // capture only where it is meaningful, and only while counting
  assign cap_go = ctrl.mode_bit && state == st_run && src_tick &&
                  !trigger_mode && (mode == mode_basic ||
                  mode == mode_window);

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      compare_active <= `RST_TIMER_REG;
    else if (cap_go)
      compare_active <= counter;
    else if (mode == mode_pulse_width && state == st_run &&
             (opp_edge || (trig_edge && !ctrl.mode_bit)))
      compare_active <= counter;
    else if (compare_pend && src_tick)
      compare_active <= compare_stage;
  end

  ////////////////////////////////////////////////////////////////////////
  // run state

  assign at_period = counter == period_active;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      state <= st_stopped;
    else if (ctrl.start_control == 2'h0)
      state <= st_stopped;
    else
    begin
      case (state)
        st_stopped:
          // 01 and gated modes run at once, edge starts wait
          if (ctrl.start_control == 2'h1 || event_mode ||
              mode == mode_window)
            state <= st_run;
          else
            state <= st_wait;
        st_wait:
          if (trig_edge)
            state <= st_run;
        st_run:
        begin
          if (trigger_mode && src_tick && at_period)
            state <= st_wait;
          else if (trigger_mode && opp_edge && !ctrl.mode_bit)
            state <= st_wait;
          else if (mode == mode_pulse_width && ctrl.mode_bit && opp_edge)
            state <= st_wait;
          else if (mode == mode_pulse_width && !ctrl.mode_bit && trig_edge)
            state <= st_wait;
          else if (mode == mode_pulse_generator && ctrl.mode_bit &&
                   src_tick && at_period)
            state <= st_wait;
        end
        default: state <= st_stopped;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // up-counter

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      counter <= 16'h0;
    else if (state != st_run)
      counter <= 16'h0;
    else if (mode == mode_pulse_width && (opp_edge || trig_edge))
    begin
      // double-edge keeps counting through the opposite edge
      if (ctrl.mode_bit || trig_edge)
        counter <= 16'h0;
    end
    else if (trigger_mode && opp_edge && !ctrl.mode_bit)
      counter <= 16'h0;
    else if (src_tick && (mode != mode_window ||
             pin_level == !ctrl.start_control[0]))
    begin
      if (at_period && mode != mode_pulse_width)
        counter <= 16'h0;
      else
        counter <= counter + 16'h1;
    end
  end

  // one-cycle pulse on each period match, except in pulse width mode
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      match_event <= 1'b0;
    else
      match_event <= state == st_run && src_tick && at_period &&
                     mode != mode_pulse_width;
  end

  ////////////////////////////////////////////////////////////////////////
  // pulse generator output

  // idle level follows the output flip-flop control bit
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      pulse_out <= 1'b0;
    else if (state == st_stopped)
      pulse_out <= ctrl.output_flipflop_control;
    else if (mode == mode_pulse_generator && state == st_run &&
             src_tick && (at_period || counter == compare_active))
      pulse_out <= !pulse_out;
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  wait_one_cycle_a: assert property (@(posedge core_clk) disable iff (rst)
    !waitrequest |=> waitrequest)
    else $error("waitrequest low for more than one cycle");

  stop_clears_start_a: assert property (@(posedge core_clk)
    disable iff (rst)
    stop_entry |=> ctrl.start_control == 2'h0 ##1 state == st_stopped)
    else $error("stop entry did not halt the timer");

  stopped_clear_a: assert property (@(posedge core_clk) disable iff (rst)
    ctrl.start_control == 2'h0 |-> ##2 counter == 16'h0)
    else $error("counter not cleared while stopped");

  lower_only_hold_a: assert property (@(posedge core_clk) disable iff (rst)
    wr_go && address == `ADDR_PERIOD && !byteenable[1] && !period_pend
    |=> period_active == $past(period_active))
    else $error("lower byte alone changed the period");

  commit_on_tick_a: assert property (@(posedge core_clk) disable iff (rst)
    period_pend && src_tick && !period_upper_wr
    |=> period_active == $past(period_stage) && !period_pend)
    else $error("period not committed on the source tick");

  capture_copy_a: assert property (@(posedge core_clk) disable iff (rst)
    cap_go |=> compare_active == $past(counter))
    else $error("auto-capture missed the counter value");

  period_clear_a: assert property (@(posedge core_clk) disable iff (rst)
    state == st_run && src_tick && at_period && mode == mode_basic &&
    !trigger_mode |=> counter == 16'h0 && match_event)
    else $error("period match did not clear the counter");

  compare_locked_a: assert property (@(posedge core_clk) disable iff (rst)
    mode != mode_pulse_generator |=> $stable(compare_stage))
    else $error("compare written outside generator mode");

endmodule : timer_counter_one_control

// >>> pin_source.sv
`timescale 1ns/10ps
// pulse source standing on the timer input pin
module pin_source
(
  input wire logic core_clk,
  output logic pin
);
  initial pin = 1'b0;

  // new level just after an edge, held for a count of edges
  task automatic drive(input logic lvl, input int cyc);
    pin <= lvl;
    repeat (cyc) @(posedge core_clk);
  endtask : drive

  // phases of 6 cycles clear the 3-cycle synchroniser
  task automatic pulses(input int n);
    repeat (n)
    begin
      drive(1'b1, 6);
      drive(1'b0, 6);
    end
  endtask : pulses
endmodule : pin_source

// >>> timer_counter_one_control_tb.sv
`timescale 1ns/10ps
`include "timer_counter_consts.svh"
module timer_counter_one_control_tb
  import timer_counter_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] address = 5'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'h0;
  logic stop_entry = 1'b0;
  logic [31:0] readdata;
  logic waitrequest;
  logic pin;
  logic pulse_out;
  logic match_event;
  logic [31:0] rd;
  int mismatches = 0;
  int cmp_count = 0;
  int sh[3] = '{`SHIFT_CODE0, `SHIFT_CODE1, `SHIFT_CODE2};

  // 4 ns core clock
  always #2 core_clk = ~core_clk;

  timer_counter_one_control i_dut
  (
    .core_clk(core_clk), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest),
    .stop_entry(stop_entry), .timer_input_pin(pin),
    .pulse_out(pulse_out), .match_event(match_event)
  );

  pin_source i_src
  (
    .core_clk(core_clk),
    .pin(pin)
  );

////////////////////////////////////////
  task automatic test_done();
    if (mismatches == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : test_done

  task automatic timeout();
    mismatches++;
    $display("Error %0t: wait ran out", $time);
    test_done();
  endtask : timeout

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // one access; request stands until waitrequest is seen low
  task automatic bus(input logic wr, input logic [4:0] a,
    input logic [31:0] d, input logic [3:0] be);
    int n;
    @(posedge core_clk);
    address <= a;
    writedata <= d;
    byteenable <= be;
    read <= ~wr;
    write <= wr;
    for (n = 0; n < 50; n++)
    begin
      @(posedge core_clk);
      if (waitrequest === 1'b0)
        break;
    end
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (n == 50)
      timeout();
  endtask : bus

  task automatic wrr(input logic [4:0] a, input logic [31:0] d,
    input logic [3:0] be);
    bus(1'b1, a, d, be);
  endtask : wrr

  task automatic rdr(input logic [4:0] a);
    bus(1'b0, a, 32'h0, 4'hF);
  endtask : rdr

  function automatic logic [31:0] cb(input logic [1:0] m, ck, s,
    input logic b6);
    timer_control_t c;
    c = '{1'b0, b6, s, ck, m};
    return {24'h0, c};
  endfunction : cb

  // drop start control alone, mode and clock kept as they stand
  task automatic halt();
    rdr(`ADDR_TIMER_CONTROL);
    wrr(`ADDR_TIMER_CONTROL, rd & 32'hCF, 4'h1);
  endtask : halt

  // halt first so mode and clock only change while stopped
  task automatic ctl(input logic [1:0] m, ck, s, input logic b6);
    halt();
    wrr(`ADDR_TIMER_CONTROL, cb(m, ck, 2'b00, b6), 4'h1);
    wrr(`ADDR_TIMER_CONTROL, cb(m, ck, s, b6), 4'h1);
  endtask : ctl

  // edges up to and including the next match pulse
  task automatic wait_match(output int c);
    for (c = 1; c < 20000; c++)
    begin
      @(posedge core_clk);
      if (match_event === 1'b1)
        break;
    end
    if (c == 20000)
      timeout();
  endtask : wait_match

////////////////////////////////////////
  task automatic t_reset();
    rdr(`ADDR_TIMER_CONTROL);
    check(rd, {24'h0, `RST_TIMER_CONTROL});
    rdr(`ADDR_PERIOD);
    check(rd, {16'h0, `RST_TIMER_REG});
    rdr(`ADDR_COMPARE);
    check(rd, {16'h0, `RST_TIMER_REG});
    wrr(5'h14, 32'hFFFFFFFF, 4'hF);
    rdr(5'h14);
    check(rd, 32'h0);
    wrr(`ADDR_TIMER_CONTROL, 32'h4E, 4'h1);
    rdr(`ADDR_TIMER_CONTROL);
    check(rd, 32'h4E);
    wrr(`ADDR_TIMER_CONTROL, 32'h0, 4'h1);
  endtask : t_reset

  task automatic t_gen();
    int t;
    logic p;
    ctl(mode_basic, 2'b10, 2'b01, 1'b0);
    wrr(`ADDR_PERIOD, 32'h0100, 4'h3);
    wrr(`ADDR_COMPARE, 32'h0008, 4'h3);
    repeat (40) @(posedge core_clk);
    rdr(`ADDR_COMPARE);
    check(rd, 32'h0000FFFF);
    rdr(`ADDR_PERIOD);
    check(rd, 32'h00000100);
    ctl(mode_pulse_generator, 2'b10, 2'b00, 1'b0);
    wrr(`ADDR_COMPARE, 32'h0008, 4'h3);
    ctl(mode_pulse_generator, 2'b10, 2'b01, 1'b0);
    repeat (40) @(posedge core_clk);
    rdr(`ADDR_COMPARE);
    check(rd, 32'h00000008);
    t = 0;
    p = pulse_out;
    repeat (200)
    begin
      @(posedge core_clk);
      t += (pulse_out !== p);
      p = pulse_out;
    end
    check(32'(t != 0), 32'd1);
  endtask : t_gen

  task automatic t_two_stage();
    int g;
    ctl(mode_basic, 2'b10, 2'b01, 1'b0);
    wrr(`ADDR_PERIOD, 32'h0005, 4'h1);
    repeat (40) @(posedge core_clk);
    rdr(`ADDR_PERIOD);
    check(rd, 32'h00000100);
    wrr(`ADDR_PERIOD, 32'h0000, 4'h2);
    repeat (40) @(posedge core_clk);
    rdr(`ADDR_PERIOD);
    check(rd, 32'h00000005);
    ctl(mode_basic, 2'b10, 2'b01, 1'b0);
    wait_match(g);
    wait_match(g);
    check(32'(g), 32'd48);
    wrr(`ADDR_PERIOD, 32'h0002, 4'h3);
    repeat (40) @(posedge core_clk);
    halt();
    // state lags start control by one edge, the counter by two
    repeat (2) @(posedge core_clk);
    rdr(`ADDR_STATUS);
    check(rd, 32'h0);
  endtask : t_two_stage

  // period 2 gives three ticks between matches
  task automatic t_rates();
    int g;
    for (int h = 0; h < 2; h++)
      for (int k = 0; k < 3; k++)
      begin
        halt();
        wrr(`ADDR_CLOCK_CONFIG, 32'(h), 4'h1);
        ctl(mode_basic, 2'(k), 2'b01, 1'b0);
        wait_match(g);
        wait_match(g);
        check(32'(g), 32'(3 << (sh[k] + h)));
      end
    halt();
    wrr(`ADDR_CLOCK_CONFIG, 32'h0, 4'h1);
  endtask : t_rates

  task automatic t_event();
    ctl(mode_basic, 2'b11, 2'b10, 1'b0);
    i_src.pulses(2);
    rdr(`ADDR_STATUS);
    check(32'(rd[15:0]), 32'd2);
    ctl(mode_basic, 2'b11, 2'b11, 1'b0);
    i_src.drive(1'b1, 6);
    rdr(`ADDR_STATUS);
    check(32'(rd[15:0]), 32'd0);
    i_src.drive(1'b0, 6);
    rdr(`ADDR_STATUS);
    check(32'(rd[15:0]), 32'd1);
  endtask : t_event

  task automatic t_trigger();
    ctl(mode_basic, 2'b10, 2'b01, 1'b0);
    wrr(`ADDR_PERIOD, 32'h0100, 4'h3);
    repeat (40) @(posedge core_clk);
    for (int b = 0; b < 2; b++)
    begin
      ctl(mode_basic, 2'b10, 2'b10, b[0]);
      i_src.drive(1'b1, 40);
      rdr(`ADDR_STATUS);
      check(32'(rd[16]), 32'd1);
      i_src.drive(1'b0, 20);
      rdr(`ADDR_STATUS);
      check(32'(rd[16]), 32'(b));
    end
  endtask : t_trigger

  // inactive level first, then the counting level
  task automatic t_window();
    for (int s = 2; s < 4; s++)
    begin
      i_src.drive(s == 3, 1);
      ctl(mode_window, 2'b10, 2'(s), 1'b0);
      repeat (40) @(posedge core_clk);
      rdr(`ADDR_STATUS);
      check(32'(rd[15:0]), 32'd0);
      i_src.drive(s == 2, 80);
      rdr(`ADDR_STATUS);
      check(32'(rd[15:0] != 16'h0), 32'd1);
    end
  endtask : t_window

  // capture trails the counter by one; three cycles hold one tick at most
  task automatic t_capture();
    logic [15:0] c;
    ctl(mode_basic, 2'b10, 2'b01, 1'b1);
    repeat (40) @(posedge core_clk);
    rdr(`ADDR_COMPARE);
    c = rd[15:0];
    rdr(`ADDR_STATUS);
    check(32'((rd[15:0] - c) inside {16'h1, 16'h2}), 32'd1);
  endtask : t_capture

  // single edge: a 40-cycle high phase spans 4 or 5 ticks of 8 cycles
  task automatic t_width();
    ctl(mode_pulse_width, 2'b10, 2'b10, 1'b1);
    i_src.drive(1'b1, 40);
    i_src.drive(1'b0, 20);
    rdr(`ADDR_COMPARE);
    check(32'(rd[15:0] inside {16'h4, 16'h5}), 32'd1);
    rdr(`ADDR_STATUS);
    check(32'(rd[16]), 32'd0);
  endtask : t_width

  task automatic t_stop();
    ctl(mode_basic, 2'b10, 2'b01, 1'b0);
    repeat (10) @(posedge core_clk);
    stop_entry <= 1'b1;
    @(posedge core_clk);
    stop_entry <= 1'b0;
    repeat (40) @(posedge core_clk);
    rdr(`ADDR_TIMER_CONTROL);
    check(rd, cb(mode_basic, 2'b10, 2'b00, 1'b0));
    rdr(`ADDR_STATUS);
    check(rd, 32'h0);
  endtask : t_stop

////////////////////////////////////////
  // reset for 4 cycles, then the scenarios in turn
  initial
  begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_gen();
    t_two_stage();
    t_rates();
    t_event();
    t_trigger();
    t_window();
    t_capture();
    t_width();
    t_stop();
    test_done();
  end
endmodule : timer_counter_one_control_tb
